// ---- ecr_cable_model.sv ----
/*
  Far party on the cable: strobes tagged bytes into the engine.
  Assumes the engine answers on ackOut within a bounded time.
*/
`timescale 1ns/1ps
module ecr_cable_model (
  // Clock.
  input wire logic clk,
  // From the engine.
  input wire logic ackOut,
  // To the engine.
  output logic strobe,
  output logic tag,
  output logic [7:0] data
);
  // ----------------------------------------------------------------------
  // Byte transfer
  // ----------------------------------------------------------------------
  initial begin
    strobe = 1'b1;
    tag = 1'b1;
    data = 8'h00;
  end

  // Sets a byte up, strobes it, waits for ack high then low; ok is 0 on a hang.
  task automatic send(input logic t, input logic [7:0] d, input int slow, output logic ok);
    int n;
    @(posedge clk);
    tag <= t;
    data <= d;
    repeat (slow + 1) @(posedge clk);
    strobe <= 1'b0;
    for (n = 0; n < 2000 && ackOut !== 1'b1; n++) @(posedge clk);
    ok = ackOut;
    strobe <= 1'b1;
    // Released lines no longer hold the byte, so show its inverse.
    data <= ~d;
    for (n = 0; n < 2000 && ackOut !== 1'b0; n++) @(posedge clk);
    ok = ok && !ackOut;
  endtask
endmodule

// ---- ecr_pkg.sv ----
/*
  Shared constants and types for the ECP receive engine: register offsets,
  field positions, reset values, receive modes, handshake states and the
  packed carrier for the synchronised cable inputs.
  Assumes a 32-bit AHB-Lite register bus and a single 40 MHz clock.
*/
// Function
// RL1: Peripheral forward modes force data lines to inputs and clear idle on entry.
// RL2: Host reverse modes force data lines to inputs and clear idle on entry.
// RL3: Peripheral waits for strobe low and request clear, then picks action.
// RL4: Tagged-data byte: latch, request, ack high; zero count waits strobe high, ack low.
// RL5: Nonzero count: each read gives a brief request gap and decrements; n+1 copies.
// RL6: Hardware RLE count byte loads counter, request stays clear, ack pulses.
// RL7: Channel address or software RLE byte is latched, request clear, idle set.
// RL8: Software reads byte, sets ack high; device clears idle, waits strobe, ack low.
// RL9: Active line falling during a peripheral byte handshake sets illegal flag.
// RL10: Software leaves ECP on active falling, aborting if illegal flag set.
// RL11: Software answers reverse request by acking and selecting reverse mode.
// RL12: Software stays in negotiation until second HostAck low, then selects forward.
// RL13: Software drives peripheral request low whenever it has data to send.
// RL14: Peripheral forward mode flags both edges of active and reverse request.
// RL15: Host waits for strobe low and request clear, then picks action.
// RL16: Host tagged-data byte: latch, request, ack high; zero count then ack low.
// RL17: Host nonzero count repeats byte with request gaps, n+1 copies.
// RL18: Host hardware RLE count byte loads counter, request clear, ack pulses.
// RL19: Host channel or software RLE byte held for software with idle set.
// RL20: Host software leaves reverse mode before turning data lines to outputs.
// RL21: Host reverse mode flags both edges of peripheral request.
package ecr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_HSHAKE = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Status fields.
  localparam int ST_IDLE = 0;
  localparam int ST_DMA_REQUEST_FLAG = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_ACT_EDGE = 3;
  localparam int ST_REV_EDGE = 4;
  localparam int ST_PREQ_EDGE = 5;
  localparam int ST_RLE_LSB = 8;

  // Handshake register: writing this bit releases a byte held for software.
  localparam int HS_RELEASE = 0;

  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] RLE_ZERO = 7'h00;
  localparam logic [6:0] RLE_ONE = 7'h01;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

  // ----------------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ECR_MODE_OFF = 3'h0,
    ECR_MODE_PFWD_HW = 3'h1,
    ECR_MODE_PFWD_SW = 3'h2,
    ECR_MODE_HREV_HW = 3'h3,
    ECR_MODE_HREV_SW = 3'h4
  } ecr_mode_t;

  typedef enum logic [4:0] {
    ECR_WAIT_LOW = 5'h01,
    ECR_HELD = 5'h02,
    ECR_GAP = 5'h04,
    ECR_WAIT_HIGH = 5'h08,
    ECR_SW_HOLD = 5'h10
  } ecr_state_t;

  // Synchronised cable inputs.
  typedef struct packed {
    logic [7:0] data;
    logic strobe;    // HostClk as peripheral, PeriphClk as host.
    logic tag;       // HostAck as peripheral, PeriphAck as host.
    logic active;    // P1284Active.
    logic revReq_n;  // nReverseRequest.
    logic perReq_n;  // nPeriphRequest.
  } ecr_link_t;

  localparam int LINK_W = $bits(ecr_link_t);

endpackage

// ---- ecr_sync.sv ----
/*
  Two-flop synchroniser for a bus of independent level inputs.
  Assumes each bit is a slow level from a pin; bits are not coherent as a word.
*/
`timescale 1ns/1ps
module ecr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Levels.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // First stage feeds only the second stage to contain metastability.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end

endmodule

// ---- ecr_top.sv ----
/*
  ECP receive engine: takes forward bytes as peripheral or reverse bytes as
  host, expands hardware run-length counts, holds channel addresses and
  software-handled counts for software, and flags illegal termination.
  Assumes an AHB-Lite master with single word transfers, a DMA channel whose
  dmaAck pulse marks a read of the holding register, and cable pins that are
  asynchronous to clk.
*/
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module ecr_top
  import ecr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // DMA.
  input wire logic dmaAck,
  output logic dmaReq,
  // Cable inputs.
  input wire logic [7:0] dataIn,
  input wire logic strobeIn,
  input wire logic tagIn,
  input wire logic activeIn,
  input wire logic revReqIn_n,
  input wire logic perReqIn_n,
  // Cable outputs.
  output logic [7:0] dataOut,
  output logic [7:0] dataOe,
  output logic ackOut
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  ecr_link_t link;
  ecr_link_t linkPrev_q;
  logic [LINK_W-1:0] linkRaw;
  logic [LINK_W-1:0] linkSync;

  assign linkRaw = {dataIn, strobeIn, tagIn, activeIn, revReqIn_n, perReqIn_n};
  assign link = ecr_link_t'(linkSync);

  ecr_sync #(
    .WIDTH(LINK_W)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn(linkRaw),
    .syncOut(linkSync)
  );

  // Delayed copy for edge detection, taken from the synchronised side only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkPrev_q <= '0;
    end else begin
      linkPrev_q <= link;
    end
  end

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  logic busValid;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic rdData;
  logic wrCtrl;
  logic wrDir;
  logic wrData;
  logic wrHshake;
  logic wrStatus;

  assign busValid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rdData = busValid && !hwrite && haddr == OFF_DATA;
  assign wrCtrl = wrPend_q && wrAddr_q == OFF_CTRL;
  assign wrDir = wrPend_q && wrAddr_q == OFF_DIR;
  assign wrData = wrPend_q && wrAddr_q == OFF_DATA;
  assign wrHshake = wrPend_q && wrAddr_q == OFF_HSHAKE;
  assign wrStatus = wrPend_q && wrAddr_q == OFF_STATUS;

  // Writes land in the data phase, when hwdata is valid.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= busValid && hwrite;
      wrAddr_q <= haddr;
    end
  end

  // Zero wait states; every answer is OKAY.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  ecr_mode_t mode_q;
  ecr_mode_t modePrev_q;
  logic [7:0] dir_q;
  logic [7:0] portOut_q;
  logic periphMode;
  logic hostMode;
  logic rxMode;
  logic hwRle;
  logic modeEntry;

  assign periphMode = mode_q == ECR_MODE_PFWD_HW || mode_q == ECR_MODE_PFWD_SW;
  assign hostMode = mode_q == ECR_MODE_HREV_HW || mode_q == ECR_MODE_HREV_SW;
  assign rxMode = periphMode || hostMode;
  assign hwRle = mode_q == ECR_MODE_PFWD_HW || mode_q == ECR_MODE_HREV_HW;
  assign modeEntry = rxMode && mode_q != modePrev_q;

  // Mode, direction and output latch; unknown mode codes fall back to off.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= ECR_MODE_OFF;
      modePrev_q <= ECR_MODE_OFF;
      dir_q <= DIR_RESET;
      portOut_q <= DATA_RESET;
    end else begin
      modePrev_q <= mode_q;
      if (wrCtrl) begin
        case (hwdata[2:0])
          ECR_MODE_PFWD_HW: mode_q <= ECR_MODE_PFWD_HW;
          ECR_MODE_PFWD_SW: mode_q <= ECR_MODE_PFWD_SW;
          ECR_MODE_HREV_HW: mode_q <= ECR_MODE_HREV_HW;
          ECR_MODE_HREV_SW: mode_q <= ECR_MODE_HREV_SW;
          default: mode_q <= ECR_MODE_OFF;
        endcase
      end
      if (wrDir) begin
        dir_q <= hwdata[7:0];
      end
      if (wrData) begin
        portOut_q <= hwdata[7:0];
      end
    end
  end

  // Receive modes own the data lines as inputs whatever the direction says.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOe <= 8'h00;
      dataOut <= DATA_RESET;
    end else begin
      dataOe <= rxMode ? 8'h00 : dir_q; // RL1 RL2
      dataOut <= portOut_q;
    end
  end

  // ----------------------------------------------------------------------
  // Receive handshake engine
  // ----------------------------------------------------------------------
  ecr_state_t state_q;
  logic [7:0] hold_q;
  logic [6:0] rle_q;
  logic idle_q;
  logic taken;

  // A read of the held byte by software or DMA takes it.
  assign taken = (rdData || dmaAck) && dmaReq;

  // One process per concern would split the handshake apart; the state,
  // counter, ack line and held byte move together, so they share one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ECR_WAIT_LOW;
      hold_q <= DATA_RESET;
      rle_q <= RLE_ZERO;
      ackOut <= 1'b0;
    end else if (!rxMode || modeEntry) begin
      state_q <= ECR_WAIT_LOW;
      ackOut <= 1'b0;
    end else begin
      case (state_q)
        ECR_WAIT_LOW: begin
          if (!link.strobe && !dmaReq) begin // RL3 RL15
            if (link.tag) begin
              hold_q <= link.data; // RL4 RL16
              ackOut <= 1'b1;
              state_q <= (rle_q == RLE_ZERO) ? ECR_WAIT_HIGH : ECR_HELD;
            end else if (!link.data[7] && hwRle) begin
              rle_q <= link.data[6:0]; // RL6 RL18
              ackOut <= 1'b1;
              state_q <= ECR_WAIT_HIGH;
            end else begin
              hold_q <= link.data; // RL7 RL19
              state_q <= ECR_SW_HOLD;
            end
          end
        end
        ECR_HELD: begin
          if (taken) begin
            rle_q <= rle_q - RLE_ONE; // RL5 RL17
            state_q <= ECR_GAP;
          end
        end
        ECR_GAP: begin
          state_q <= (rle_q == RLE_ZERO) ? ECR_WAIT_HIGH : ECR_HELD; // RL5 RL17
        end
        ECR_WAIT_HIGH: begin
          if (link.strobe) begin
            ackOut <= 1'b0; // RL4 RL16
            state_q <= ECR_WAIT_LOW;
          end
        end
        ECR_SW_HOLD: begin
          if (wrHshake && hwdata[HS_RELEASE]) begin
            ackOut <= 1'b1; // RL8 RL19
            state_q <= ECR_WAIT_HIGH;
          end
        end
        default: begin
          state_q <= ECR_WAIT_LOW;
        end
      endcase
    end
  end

  // DMA request: set on a tagged byte and after each repeat gap, cleared
  // by a read; a set in the same cycle as a read wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmaReq <= 1'b0;
    end else if (!rxMode) begin
      dmaReq <= 1'b0;
    end else if (state_q == ECR_WAIT_LOW && !link.strobe && !dmaReq && link.tag) begin
      dmaReq <= 1'b1; // RL4 RL16
    end else if (state_q == ECR_GAP) begin
      dmaReq <= 1'b1; // RL5 RL17
    end else if (taken) begin
      dmaReq <= 1'b0;
    end
  end

  // Idle: cleared on mode entry and on release, set only for a held byte.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_q <= 1'b0;
    end else if (modeEntry) begin
      idle_q <= 1'b0; // RL1 RL2
    end else if (rxMode && state_q == ECR_WAIT_LOW && !link.strobe && !dmaReq && !link.tag &&
                 (link.data[7] || !hwRle)) begin
      idle_q <= 1'b1; // RL7 RL19
    end else if (rxMode && state_q == ECR_SW_HOLD && wrHshake && hwdata[HS_RELEASE]) begin
      idle_q <= 1'b0; // RL8 RL19
    end
  end

  // ----------------------------------------------------------------------
  // Termination and line-change flags
  // ----------------------------------------------------------------------
  logic illegal_q;
  logic actEdge_q;
  logic revEdge_q;
  logic preqEdge_q;
  logic actFall;
  logic inByte;

  assign actFall = linkPrev_q.active && !link.active;
  // A byte is in progress from strobe low until the ack line is back low.
  assign inByte = !link.strobe || ackOut || state_q != ECR_WAIT_LOW;

  // Sticky flags, write one to clear; a new event in the clearing cycle wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      illegal_q <= 1'b0;
      actEdge_q <= 1'b0;
      revEdge_q <= 1'b0;
      preqEdge_q <= 1'b0;
    end else begin
      if (periphMode && actFall && inByte) begin
        illegal_q <= 1'b1; // RL9
      end else if (wrStatus && hwdata[ST_ILLEGAL]) begin
        illegal_q <= 1'b0;
      end
      if (periphMode && linkPrev_q.active != link.active) begin
        actEdge_q <= 1'b1; // RL14
      end else if (wrStatus && hwdata[ST_ACT_EDGE]) begin
        actEdge_q <= 1'b0;
      end
      if (periphMode && linkPrev_q.revReq_n != link.revReq_n) begin
        revEdge_q <= 1'b1; // RL14
      end else if (wrStatus && hwdata[ST_REV_EDGE]) begin
        revEdge_q <= 1'b0;
      end
      if (hostMode && linkPrev_q.perReq_n != link.perReq_n) begin
        preqEdge_q <= 1'b1; // RL21
      end else if (wrStatus && hwdata[ST_PREQ_EDGE]) begin
        preqEdge_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rdMux;

  // Read value is chosen in the address phase so it stands in the data phase.
  always_comb begin
    rdMux = 32'h0000_0000;
    case (haddr)
      OFF_CTRL: rdMux[2:0] = mode_q;
      OFF_DIR: rdMux[7:0] = dir_q;
      OFF_DATA: rdMux[7:0] = hold_q;
      OFF_STATUS: begin
        rdMux[ST_IDLE] = idle_q;
        rdMux[ST_DMA_REQUEST_FLAG] = dmaReq;
        rdMux[ST_ILLEGAL] = illegal_q;
        rdMux[ST_ACT_EDGE] = actEdge_q;
        rdMux[ST_REV_EDGE] = revEdge_q;
        rdMux[ST_PREQ_EDGE] = preqEdge_q;
        rdMux[ST_RLE_LSB +: 7] = rle_q;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (busValid && !hwrite) begin
      hrdata <= rdMux;
    end
  end

endmodule

// ---- ecr_top_asserts.sv ----
/*
  Port checker for the ECP receive engine.
  Assumes it is bound to ecr_top and sees only its ports.
*/
`timescale 1ns/1ps
module ecr_top_asserts
  import ecr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Bus.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Engine.
  input wire logic dmaAck,
  input wire logic dmaReq,
  input wire logic strobeIn,
  input wire logic [7:0] dataOe,
  input wire logic ackOut
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // A read address phase; at the data offset it takes the held byte.
  wire logic rdTake = hsel && hready && htrans[1] && !hwrite;
  wire logic dataTake = rdTake && haddr == OFF_DATA;

  bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus not ready or not okay");
  unmapped_zero_a: assert property (rdTake && haddr == 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  recv_inputs_a: assert property (ackOut || dmaReq |-> dataOe == 8'h00)
    else $error("data lines driven while receiving");
  // Two synchroniser flops plus the decision edge put the sampled strobe three edges back.
  ack_cause_a: assert property ($rose(ackOut) |-> !$past(strobeIn, 3))
    else $error("ack rose without strobe low");
  ack_release_a: assert property ($fell(ackOut) |-> $past(strobeIn, 3))
    else $error("ack fell before strobe high");
  ack_hold_a: assert property (ackOut && !strobeIn |=> ackOut)
    else $error("ack dropped while strobe low");
  req_with_ack_a: assert property ($rose(dmaReq) |-> ackOut)
    else $error("request rose without ack");
  req_hold_a: assert property (dmaReq && !dmaAck && !dataTake |=> dmaReq)
    else $error("request dropped without a read");
  req_take_a: assert property (dmaReq && dataTake |=> !dmaReq)
    else $error("request stayed high after a read");

  // Main scenarios.
  data_cov: cover property ($rose(dmaReq));
  count_cov: cover property ($rose(ackOut) && !dmaReq);
  gap_cov: cover property ($fell(dmaReq) ##1 dmaReq);
endmodule

bind ecr_top ecr_top_asserts ecr_top_asserts_inst (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .dmaAck, .dmaReq, .strobeIn, .dataOe, .ackOut);

// ---- ecr_top_tb.sv ----
/*
  Bench for ecr_top: AHB-Lite tasks, cable partner, random bytes and corners.
  Assumes ecr_cable_model stands for the far party on the cable.
*/
`timescale 1ns/1ps
module ecr_top_tb
  import ecr_pkg::*;
;
  logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, dmaAck, dmaReq, ackOut, ok;
  logic strobeIn, tagIn, activeIn, revReqIn_n, perReqIn_n;
  logic [7:0] haddr, dataIn, dataOut, dataOe, d, c;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, r;
  int failures, checks_done;

  // One slave, so its ready is the bus ready.
  assign hready = hreadyout;

  ecr_top ecr_top_inst (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .dmaAck, .dmaReq, .dataIn, .strobeIn, .tagIn, .activeIn, .revReqIn_n,
    .perReqIn_n, .dataOut, .dataOe, .ackOut);
  ecr_cable_model ecr_cable_model_inst (.clk, .ackOut, .strobe(strobeIn), .tag(tagIn), .data(dataIn));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A wait that runs out counts as a mismatch and ends the run.
  task automatic give_up(input logic done);
    if (!done) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic edge_ready();
    int n;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    give_up(1'b0);
  endtask

  // One single word transfer; read data lands in r.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    r = hrdata;
  endtask

  // Waits for the request, then takes the byte by a bus read or a DMA pulse.
  task automatic take(input logic [7:0] b);
    int n;
    // Start on a falling edge so a request cleared at this edge is not seen stale.
    @(negedge clk);
    for (n = 0; n < 300 && dmaReq !== 1'b1; n++) @(negedge clk);
    give_up(dmaReq === 1'b1);
    if ($urandom_range(1) == 1) begin
      bus(1'b0, OFF_DATA, 32'h0);
      check("byte", b, r[7:0]);
    end else begin
      @(posedge clk);
      dmaAck <= 1'b1;
      @(posedge clk);
      dmaAck <= 1'b0;
    end
  endtask

  // Waits for a byte held for software, optionally drops active, then releases.
  task automatic hold(input logic [7:0] b, input logic drop);
    int n;
    // Forget the last read so an earlier data byte cannot pose as the idle flag.
    r = 32'h0;
    for (n = 0; n < 40 && r[ST_IDLE] !== 1'b1; n++) bus(1'b0, OFF_STATUS, 32'h0);
    give_up(r[ST_IDLE] === 1'b1);
    check("held request", 1'b0, r[ST_DMA_REQUEST_FLAG]);
    if (drop) begin
      activeIn <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("illegal end", 2'h3, r[3:2]);
      activeIn <= 1'b1;
    end
    bus(1'b0, OFF_DATA, 32'h0);
    check("held byte", b, r[7:0]);
    bus(1'b1, OFF_HSHAKE, 32'h1);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("idle after release", 1'b0, r[ST_IDLE]);
  endtask

  function automatic logic hw(input int k);
    return k == ECR_MODE_PFWD_HW || k == ECR_MODE_HREV_HW;
  endfunction

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    {hsel, hwrite, dmaAck, rst_b} = 4'h0;
    {activeIn, revReqIn_n, perReqIn_n} = 3'h7;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    d = $urandom(32'hE2B0);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, r);
    bus(1'b1, OFF_DATA, ~d);
    bus(1'b1, OFF_DIR, d);
    bus(1'b0, OFF_DIR, 32'h0);
    check("direction", d, r);
    check("drive off mode", d, dataOe);
    check("out latch", {24'h0, ~d}, dataOut);
    // Every receive mode: a full count, random counts, channel bytes.
    for (int k = 1; k < 5; k++) begin
      bus(1'b1, OFF_CTRL, k);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("entry idle", 1'b0, r[ST_IDLE]);
      check("receive drive", 8'h00, dataOe);
      for (int j = 0; j < 3; j++) begin
        c = (j == 0) ? 8'h7F : 8'($urandom_range(3));
        d = $urandom;
        fork
          ecr_cable_model_inst.send(1'b0, c, $urandom_range(3), ok);
          if (!hw(k)) hold(c, 1'b0);
        join
        check("partner done", 1'b1, ok);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("count", hw(k) ? c : 8'h00, r[14:8]);
        fork
          ecr_cable_model_inst.send(1'b1, d, $urandom_range(3), ok);
          repeat (hw(k) ? c + 1 : 1) take(d);
        join
        check("partner done", 1'b1, ok);
        repeat (6) @(posedge clk);
        check("no extra copy", 1'b0, dmaReq);
        d = $urandom | 8'h80;
        fork
          ecr_cable_model_inst.send(1'b0, d, 1, ok);
          hold(d, k == 1 && j == 2);
        join
        check("partner done", 1'b1, ok);
      end
    end
    perReqIn_n <= 1'b0;
    repeat (6) @(posedge clk);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("request edge", 1'b1, r[ST_PREQ_EDGE]);
    // Host software leaves reverse mode before it turns the data lines around.
    bus(1'b1, OFF_CTRL, ECR_MODE_OFF);
    bus(1'b1, OFF_DIR, 32'hA5);
    bus(1'b0, OFF_DIR, 32'h0);
    check("drive after reverse", 8'hA5, dataOe);
    bus(1'b1, OFF_CTRL, ECR_MODE_PFWD_SW);
    bus(1'b1, OFF_STATUS, 32'h3C);
    revReqIn_n <= 1'b0;
    activeIn <= 1'b0;
    repeat (6) @(posedge clk);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("legal end", 3'h6, r[4:2]);
    bus(1'b1, OFF_CTRL, ECR_MODE_OFF);
    finish_test();
  end
endmodule
